// ==== irt_dual_timer.sv ====
// Dual infrared timer: narrow and wide counters, capture, waveform and register bank
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps

module irt_dual_timer
  import irt_pkg::*;
(
  // Clock and resets
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       STOP_RECOVERY,
  // Register port
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Pins
  input  wire logic       COMPARATOR_INPUT_PIN,
  input  wire logic       PORT_INPUT_PIN,
  input  wire logic       PORT_DATA_FIRST,
  input  wire logic       PORT_DATA_THIRD,
  output logic            FIRST_TIMER_OUTPUT_PIN,
  output logic            THIRD_TIMER_OUTPUT_PIN,
  // Interrupt requests
  output logic            CAPTURE_IRQ,
  output logic            TIMEOUT_IRQ
);

  irt_narrow_ctrl_s nctl, next_nctl;
  irt_shared_ctrl_s sctl, next_sctl;
  logic        wide_en, wide_single, wide_to;
  logic        next_wide_en, next_wide_to;
  logic [7:0]  n_low_hold, n_high_hold, n_cap;
  logic [15:0] w_hold, w_cap;
  logic [7:0]  n_cnt, next_n_cnt;
  logic [15:0] w_cnt, next_w_cnt;
  logic        n_out, next_n_out, w_out, next_w_out;
  logic [2:0]  pre_cnt;
  logic        filt_lvl;
  logic [3:0]  stab_cnt;

  // Register decode
  wire wr_nctl   = REG_WR && (REG_ADDR == ADDR_NARROW_CTRL);
  wire wr_sctl   = REG_WR && (REG_ADDR == ADDR_SHARED_CTRL);
  wire wr_wctl   = REG_WR && (REG_ADDR == ADDR_WIDE_CTRL);
  wire wr_n_low  = REG_WR && (REG_ADDR == ADDR_NARROW_LOW_HOLD);
  wire wr_n_high = REG_WR && (REG_ADDR == ADDR_NARROW_HIGH_HOLD);
  wire wr_w_low  = REG_WR && (REG_ADDR == ADDR_WIDE_RELOAD_LOW);
  wire wr_w_high = REG_WR && (REG_ADDR == ADDR_WIDE_RELOAD_HIGH);

  wire       demod = sctl.edge_mode;
  wire       alt   = !demod && (irt_submode_e'(sctl.submode) == SUB_ALTERNATING);

  // Prescaler: the free-running divider lets the first tick arrive early
  wire [2:0] pre_mask = (nctl.clk_sel == 2'b00) ? DIV1_MASK :
                        (nctl.clk_sel == 2'b01) ? DIV2_MASK :
                        (nctl.clk_sel == 2'b10) ? DIV4_MASK : DIV8_MASK;
  wire       n_tick   = nctl.enable && ((pre_cnt & pre_mask) == pre_mask);
  wire       w_tick   = wide_en;

  // Input select and glitch filter
  wire       raw_in   = sctl.route ? PORT_INPUT_PIN : COMPARATOR_INPUT_PIN;
  wire [3:0] need     = (sctl.submode == 2'b01) ? FILTER_SHORT :
                        (sctl.submode == 2'b10) ? FILTER_LONG : FILTER_NONE;
  wire [3:0] stab_nxt = stab_cnt + 4'h1;
  wire       flip     = (raw_in != filt_lvl) && (stab_nxt >= need);
  wire       rise_evt = demod && flip && raw_in;
  wire       fall_evt = demod && flip && !raw_in;
  wire       sel_rise = (irt_edge_e'(sctl.combine) == EDGE_RISING) ||
                        (irt_edge_e'(sctl.combine) == EDGE_BOTH);
  wire       sel_fall = (irt_edge_e'(sctl.combine) == EDGE_FALLING) ||
                        (irt_edge_e'(sctl.combine) == EDGE_BOTH);
  wire       det_rise = rise_evt && sel_rise;
  wire       det_fall = fall_evt && sel_fall;
  wire       cap_evt  = det_rise || det_fall;
  wire       n_cap_en = cap_evt && det_rise && nctl.enable;
  wire       w_cap_en = cap_evt && wide_en;

  // Terminal counts and starts
  wire n_term      = n_tick && (demod ? (n_cnt == 8'hff) : (n_cnt == 8'h00));
  wire w_term      = w_tick && (w_cnt == 16'h0000);
  wire pp_to_wide  = alt && n_term;
  wire pp_to_nar   = alt && w_term;
  wire n_load      = (wr_nctl && REG_WDATA[BIT_ENABLE] && !nctl.enable) || pp_to_nar;
  wire w_load      = (wr_wctl && REG_WDATA[BIT_ENABLE] && !wide_en) || pp_to_wide;

  // Wide output forcing and output combining
  wire w_eff = demod ? w_out :
               (irt_submode_e'(sctl.submode) == SUB_FORCE_LOW)  ? 1'b0 :
               (irt_submode_e'(sctl.submode) == SUB_FORCE_HIGH) ? 1'b1 : w_out;
  wire comb_out = (irt_logic_e'(sctl.combine) == LOGIC_AND) ? (n_out & w_eff) :
                  (irt_logic_e'(sctl.combine) == LOGIC_OR)  ? (n_out | w_eff) :
                  (irt_logic_e'(sctl.combine) == LOGIC_NOR) ? ~(n_out | w_eff) :
                  ~(n_out & w_eff);

  // Read mux
  wire [7:0] rd_data = (REG_ADDR == ADDR_NARROW_CTRL)      ? nctl :
                       (REG_ADDR == ADDR_SHARED_CTRL)      ? sctl :
                       (REG_ADDR == ADDR_WIDE_CTRL)        ? {wide_en, wide_single, wide_to, 5'h00} :
                       (REG_ADDR == ADDR_NARROW_LOW_HOLD)  ? n_low_hold :
                       (REG_ADDR == ADDR_NARROW_HIGH_HOLD) ? n_high_hold :
                       (REG_ADDR == ADDR_WIDE_RELOAD_LOW)  ? w_hold[7:0] :
                       (REG_ADDR == ADDR_WIDE_RELOAD_HIGH) ? w_hold[15:8] :
                       (REG_ADDR == ADDR_WIDE_CAP_LOW)     ? w_cap[7:0] :
                       (REG_ADDR == ADDR_WIDE_CAP_HIGH)    ? w_cap[15:8] :
                       (REG_ADDR == ADDR_NARROW_CAP_LOW)   ? n_cap : READ_IDLE;

  // Control register next values; hardware set wins over a write-one clear
  always_comb begin
    next_nctl = nctl;
    if (wr_nctl) begin
      next_nctl         = irt_narrow_ctrl_s'(REG_WDATA);
      next_nctl.timeout = nctl.timeout && !REG_WDATA[BIT_TIMEOUT];
    end else if (n_term && (nctl.single || alt)) begin
      next_nctl.enable = 1'b0;
    end else if (pp_to_nar) begin
      next_nctl.enable = 1'b1;
    end
    if (n_term) begin
      next_nctl.timeout = 1'b1;
    end
    next_sctl = sctl;
    if (wr_sctl) begin
      next_sctl = irt_shared_ctrl_s'(REG_WDATA);
      if (demod) begin
        next_sctl.rise = sctl.rise && !REG_WDATA[BIT_RISE];
        next_sctl.fall = sctl.fall && !REG_WDATA[BIT_FALL];
      end
    end
    if (rise_evt) begin
      next_sctl.rise = 1'b1;
    end
    if (fall_evt) begin
      next_sctl.fall = 1'b1;
    end
    next_wide_en = wide_en;
    if (wr_wctl) begin
      next_wide_en = REG_WDATA[BIT_ENABLE];
    end else if (w_term && (wide_single || alt)) begin
      next_wide_en = 1'b0;
    end else if (pp_to_wide) begin
      next_wide_en = 1'b1;
    end
    next_wide_to = w_term || (wide_to && !(wr_wctl && REG_WDATA[BIT_TIMEOUT]));
  end

  // Narrow counter and waveform
  always_comb begin
    next_n_cnt = n_cnt;
    next_n_out = n_out;
    if (n_load) begin
      next_n_cnt = demod ? 8'h00 : (sctl.rise ? n_high_hold : n_low_hold);
      next_n_out = sctl.rise;
    end else if (!nctl.enable) begin
      next_n_out = !sctl.rise;
    end else if (rise_evt || fall_evt) begin
      next_n_cnt = 8'h00;
    end else if (n_term) begin
      if (!demod) begin
        next_n_out = !n_out;
        next_n_cnt = n_out ? n_low_hold : n_high_hold;
      end
    end else if (n_tick) begin
      next_n_cnt = demod ? n_cnt + 8'h01 : n_cnt - 8'h01;
    end
  end

  // Wide counter and waveform
  always_comb begin
    next_w_cnt = w_cnt;
    next_w_out = w_out;
    if (w_load) begin
      next_w_cnt = w_hold;
      next_w_out = sctl.fall;
    end else if (!wide_en) begin
      next_w_out = !sctl.fall;
    end else if (demod && cap_evt) begin
      next_w_cnt = w_hold;
    end else if (w_term) begin
      next_w_cnt = w_hold;
      next_w_out = demod ? w_out : !w_out;
    end else if (w_tick) begin
      next_w_cnt = w_cnt - 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      nctl        <= irt_narrow_ctrl_s'(CTRL_RESET);
      sctl        <= irt_shared_ctrl_s'(CTRL_RESET);
      wide_en     <= 1'b0;
      wide_single <= 1'b0;
      wide_to     <= 1'b0;
    end else if (STOP_RECOVERY) begin
      nctl.enable  <= 1'b0;
      nctl.single  <= 1'b0;
      nctl.pin_sel <= 1'b0;
      sctl.edge_mode <= 1'b0;
      sctl.route     <= 1'b0;
      wide_en        <= 1'b0;
    end else begin
      nctl    <= next_nctl;
      sctl    <= next_sctl;
      wide_en <= next_wide_en;
      wide_to <= next_wide_to;
      if (wr_wctl) begin
        wide_single <= REG_WDATA[6];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      n_low_hold  <= DATA_RESET;
      n_high_hold <= DATA_RESET;
      w_hold      <= WIDE_RESET;
    end else begin
      if (wr_n_low) begin
        n_low_hold <= REG_WDATA;
      end
      if (wr_n_high) begin
        n_high_hold <= REG_WDATA;
      end
      if (wr_w_low) begin
        w_hold[7:0] <= REG_WDATA;
      end
      if (wr_w_high) begin
        w_hold[15:8] <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      n_cap <= DATA_RESET;
      w_cap <= WIDE_RESET;
    end else begin
      if (n_cap_en) begin
        n_cap <= n_cnt;
      end
      if (w_cap_en) begin
        w_cap <= w_cnt;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      n_cnt    <= DATA_RESET;
      w_cnt    <= WIDE_RESET;
      n_out    <= 1'b1;
      w_out    <= 1'b1;
      pre_cnt  <= 3'h0;
      filt_lvl <= 1'b0;
      stab_cnt <= 4'h0;
    end else begin
      n_cnt    <= next_n_cnt;
      w_cnt    <= next_w_cnt;
      n_out    <= next_n_out;
      w_out    <= next_w_out;
      pre_cnt  <= pre_cnt + 3'h1;
      filt_lvl <= flip ? raw_in : filt_lvl;
      stab_cnt <= (raw_in == filt_lvl || flip) ? 4'h0 : stab_nxt;
    end
  end

  // Pins, interrupts and read data all leave from flip-flops
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      REG_RDATA              <= READ_IDLE;
      FIRST_TIMER_OUTPUT_PIN <= 1'b0;
      THIRD_TIMER_OUTPUT_PIN <= 1'b0;
      CAPTURE_IRQ            <= 1'b0;
      TIMEOUT_IRQ            <= 1'b0;
    end else begin
      REG_RDATA              <= REG_RD ? rd_data : READ_IDLE;
      FIRST_TIMER_OUTPUT_PIN <= nctl.pin_sel ? n_out : PORT_DATA_FIRST;
      THIRD_TIMER_OUTPUT_PIN <= (!demod && sctl.route) ? comb_out : PORT_DATA_THIRD;
      CAPTURE_IRQ            <= nctl.cap_mask && demod && (sctl.rise || sctl.fall);
      TIMEOUT_IRQ            <= nctl.to_mask && nctl.timeout;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  AST_NARROW_CAP_RO: assert property (
    (REG_WR && REG_ADDR == ADDR_NARROW_CAP_LOW && !n_cap_en) |=> $stable(n_cap))
    else $error("narrow capture changed by a write");
  AST_WIDE_CAP_RO: assert property (
    (REG_WR && REG_ADDR == ADDR_WIDE_CAP_HIGH && !w_cap_en) |=> $stable(w_cap))
    else $error("wide capture changed by a write");
  AST_WIDE_HOLD_WR: assert property (
    wr_w_low |=> w_hold[7:0] == $past(REG_WDATA))
    else $error("wide low hold not written");
  AST_NARROW_HOLD_RD: assert property (
    wr_n_high ##1 !wr_n_high ##1 (REG_RD && REG_ADDR == ADDR_NARROW_HIGH_HOLD) |=> REG_RDATA == $past(REG_WDATA, 3))
    else $error("narrow high hold read back wrong");
  AST_ENABLE_WR: assert property (
    (wr_nctl && !STOP_RECOVERY) |=> nctl.enable == $past(REG_WDATA[BIT_ENABLE]))
    else $error("narrow enable does not follow write");
  AST_SINGLE_STOP: assert property (
    (n_term && nctl.single && !wr_nctl && !STOP_RECOVERY) |=> !nctl.enable)
    else $error("single pass did not stop");
  AST_TIMEOUT_SET: assert property (
    n_term |=> nctl.timeout)
    else $error("timeout flag not set at terminal count");
  AST_TIMEOUT_IRQ_MASK: assert property (
    !nctl.to_mask |=> !TIMEOUT_IRQ)
    else $error("timeout interrupt while masked");
  AST_CAPTURE_IRQ_CAUSE: assert property (
    CAPTURE_IRQ |-> $past(nctl.cap_mask) && $past(demod))
    else $error("capture interrupt without mask or edge mode");
  AST_PIN_ROUTE: assert property (
    nctl.pin_sel |=> FIRST_TIMER_OUTPUT_PIN == $past(n_out))
    else $error("first pin does not carry narrow output");
  AST_STOP_KEEPS: assert property (
    STOP_RECOVERY |=> !nctl.enable && nctl.clk_sel == $past(nctl.clk_sel) && nctl.to_mask == $past(nctl.to_mask))
    else $error("stop recovery disturbed kept fields");
  AST_TIMEOUT_CLEAR: assert property (
    (wr_nctl && REG_WDATA[BIT_TIMEOUT] && !n_term && !STOP_RECOVERY) |=> !nctl.timeout)
    else $error("timeout flag not cleared by writing one");
  AST_TIMEOUT_KEEP: assert property (
    (wr_nctl && !REG_WDATA[BIT_TIMEOUT] && nctl.timeout && !STOP_RECOVERY) |=> nctl.timeout)
    else $error("timeout flag lost by writing zero");
  AST_RISE_FLAG_SET: assert property (
    (rise_evt && !STOP_RECOVERY) |=> sctl.rise)
    else $error("rising edge flag not set");
  AST_RISE_FLAG_CLEAR: assert property (
    (wr_sctl && demod && REG_WDATA[BIT_RISE] && !rise_evt && !STOP_RECOVERY) |=> !sctl.rise)
    else $error("rising edge flag not cleared by writing one");
  AST_LOW_CAPTURE: assert property (
    n_cap_en |=> n_cap == $past(n_cnt))
    else $error("narrow capture does not hold the count");
  AST_LOW_COUNT_CLEAR: assert property (
    (fall_evt && nctl.enable) |=> n_cnt == 8'h00)
    else $error("narrow count not restarted at falling edge");
  AST_PRESCALE: assert property (
    (n_tick && nctl.clk_sel != 2'b00 && !wr_nctl) |=> !n_tick)
    else $error("divided count clock ticked twice in a row");
  AST_THIRD_ROUTE: assert property (
    (!demod && sctl.route) |=> THIRD_TIMER_OUTPUT_PIN == $past(comb_out))
    else $error("third pin does not carry combined output");

  COV_NARROW_TERM: cover property (n_term ##[1:8] TIMEOUT_IRQ);
  COV_CAPTURE: cover property (n_cap_en ##[1:4] CAPTURE_IRQ);
  COV_ALTERNATE: cover property (pp_to_wide);
  COV_WIDE_CAPTURE: cover property (w_cap_en);

endmodule // irt_dual_timer

// ==== irt_pin_model.sv ====
// Pin-side model: receiver input lines and ordinary port data for the timer pins
`timescale 1ns/1ps

module irt_pin_model (
  // Clock
  input  wire logic CLK,
  // Lines toward the block
  output logic      COMPARATOR_INPUT_PIN,
  output logic      PORT_INPUT_PIN,
  output logic      PORT_DATA_FIRST,
  output logic      PORT_DATA_THIRD,
  // Pins from the block
  input  wire logic FIRST_TIMER_OUTPUT_PIN,
  input  wire logic THIRD_TIMER_OUTPUT_PIN
);
  // Receiver idles high; the unselected port input stays quiet so it never makes an edge
  initial begin
    COMPARATOR_INPUT_PIN = 1'b1;
    PORT_INPUT_PIN       = 1'b1;
    PORT_DATA_FIRST      = 1'b0;
    PORT_DATA_THIRD      = 1'b0;
  end

  task automatic set_rx(input logic v);
    @(posedge CLK);
    COMPARATOR_INPUT_PIN <= v;
  endtask

  task automatic set_port(input logic f, input logic t);
    @(posedge CLK);
    PORT_DATA_FIRST <= f;
    PORT_DATA_THIRD <= t;
  endtask
endmodule // irt_pin_model

// ==== irt_pkg.sv ====
// Constants, register map and carrier types for the dual infrared timer block
package irt_pkg;

  // Register offsets in the timer register bank
  localparam logic [3:0] ADDR_NARROW_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_SHARED_CTRL      = 4'h1;
  localparam logic [3:0] ADDR_WIDE_CTRL        = 4'h2;
  localparam logic [3:0] ADDR_NARROW_LOW_HOLD  = 4'h4;
  localparam logic [3:0] ADDR_NARROW_HIGH_HOLD = 4'h5;
  localparam logic [3:0] ADDR_WIDE_RELOAD_LOW  = 4'h6;
  localparam logic [3:0] ADDR_WIDE_RELOAD_HIGH = 4'h7;
  localparam logic [3:0] ADDR_WIDE_CAP_LOW     = 4'h8;
  localparam logic [3:0] ADDR_WIDE_CAP_HIGH    = 4'h9;
  localparam logic [3:0] ADDR_NARROW_CAP_LOW   = 4'ha;

  // Field positions shared by the control registers
  localparam int BIT_ENABLE  = 7;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_RISE    = 1;
  localparam int BIT_FALL    = 0;

  // Reset values
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  DATA_RESET = 8'h00;
  localparam logic [15:0] WIDE_RESET = 16'h0000;
  localparam logic [7:0]  READ_IDLE  = 8'h00;

  // Glitch filter lengths in system clock cycles
  localparam logic [3:0] FILTER_NONE  = 4'h1;
  localparam logic [3:0] FILTER_SHORT = 4'h4;
  localparam logic [3:0] FILTER_LONG  = 4'h8;

  // Prescaler masks for divide by 1, 2, 4 and 8
  localparam logic [2:0] DIV1_MASK = 3'h0;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

  typedef enum logic [1:0] {LOGIC_AND, LOGIC_OR, LOGIC_NOR, LOGIC_NAND} irt_logic_e;
  typedef enum logic [1:0] {EDGE_FALLING, EDGE_RISING, EDGE_BOTH, EDGE_RESERVED} irt_edge_e;
  typedef enum logic [1:0] {SUB_NORMAL, SUB_ALTERNATING, SUB_FORCE_LOW, SUB_FORCE_HIGH} irt_submode_e;

  typedef struct packed {
    logic       enable;
    logic       single;
    logic       timeout;
    logic [1:0] clk_sel;
    logic       cap_mask;
    logic       to_mask;
    logic       pin_sel;
  } irt_narrow_ctrl_s;

  typedef struct packed {
    logic       edge_mode;
    logic       route;
    logic [1:0] combine;
    logic [1:0] submode;
    logic       rise;
    logic       fall;
  } irt_shared_ctrl_s;

endpackage

// ==== tb_top.sv ====
// Self-checking testbench for the dual infrared timer block
`timescale 1ns/1ps

module tb_top
  import irt_pkg::*;
;
  logic       CLK = 1'b0;
  logic       RST_B = 1'b0;
  logic       STOP_RECOVERY = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [7:0] REG_WDATA = 8'h00;
  logic       REG_WR = 1'b0;
  logic       REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic       cmp_pin, port_pin, pd_first, pd_third, first_pin, third_pin;
  logic       CAPTURE_IRQ, TIMEOUT_IRQ;
  int         error_cnt = 0;
  int         checked = 0;
  int         cyc = 0;

  always #10 CLK = ~CLK;

  irt_dual_timer irt_dual_timer_i (.CLK(CLK), .RST_B(RST_B), .STOP_RECOVERY(STOP_RECOVERY),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .COMPARATOR_INPUT_PIN(cmp_pin), .PORT_INPUT_PIN(port_pin), .PORT_DATA_FIRST(pd_first),
    .PORT_DATA_THIRD(pd_third), .FIRST_TIMER_OUTPUT_PIN(first_pin), .THIRD_TIMER_OUTPUT_PIN(third_pin),
    .CAPTURE_IRQ(CAPTURE_IRQ), .TIMEOUT_IRQ(TIMEOUT_IRQ));

  irt_pin_model irt_pin_model_i (.CLK(CLK), .COMPARATOR_INPUT_PIN(cmp_pin), .PORT_INPUT_PIN(port_pin),
    .PORT_DATA_FIRST(pd_first), .PORT_DATA_THIRD(pd_third), .FIRST_TIMER_OUTPUT_PIN(first_pin),
    .THIRD_TIMER_OUTPUT_PIN(third_pin));

  task automatic print_verdict();
    $display("Checks made: %0d, mismatches: %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Run ceiling, well above the few hundred cycles the tests need
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("Error at %0t: run timed out", $time);
      print_verdict();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD   <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic wait_timeout(input int lim, output int n);
    n = 0;
    while (TIMEOUT_IRQ !== 1'b1 && n < lim) begin
      @(posedge CLK);
      #1;
      n++;
    end
  endtask

  task automatic t_reset();
    logic [7:0] d;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), d);
      chk(d, 8'h00, "reset value");
    end
    $display("Test reset values done");
  endtask

  task automatic t_regs();
    logic [7:0] d;
    for (int a = 4; a < 8; a++)
      wr(4'(a), 8'h5a ^ 8'(a));
    for (int a = 8; a < 11; a++)
      wr(4'(a), 8'hff);
    wr(4'hf, 8'hff);
    for (int a = 4; a < 8; a++) begin
      rd(4'(a), d);
      chk(d, 8'h5a ^ 8'(a), "hold register");
    end
    for (int a = 8; a < 11; a++) begin
      rd(4'(a), d);
      chk(d, 8'h00, "capture register write");
    end
    rd(4'hf, d);
    chk(d, 8'h00, "unmapped offset");
    wr(ADDR_NARROW_HIGH_HOLD, 8'ha5);
    rd(ADDR_NARROW_HIGH_HOLD, d);
    chk(d, 8'ha5, "hold register write then read");
    $display("Test register access done");
  endtask

  task automatic t_stop();
    logic [7:0] d;
    wr(ADDR_NARROW_CTRL, 8'h5f);
    wr(ADDR_SHARED_CTRL, 8'h7f);
    rd(ADDR_NARROW_CTRL, d);
    chk(d, 8'h5f, "narrow control");
    rd(ADDR_SHARED_CTRL, d);
    chk(d, 8'h7f, "shared control");
    @(posedge CLK);
    STOP_RECOVERY <= 1'b1;
    @(posedge CLK);
    STOP_RECOVERY <= 1'b0;
    rd(ADDR_NARROW_CTRL, d);
    chk(d, 8'h1e, "narrow control after stop recovery");
    rd(ADDR_SHARED_CTRL, d);
    chk(d, 8'h3f, "shared control after stop recovery");
    wr(ADDR_SHARED_CTRL, 8'h00);
    wr(ADDR_NARROW_CTRL, 8'h00);
    $display("Test stop recovery done");
  endtask

  task automatic t_timeout();
    logic [7:0] d;
    int n;
    wr(ADDR_NARROW_LOW_HOLD, 8'h02);
    wr(ADDR_NARROW_HIGH_HOLD, 8'h02);
    wr(ADDR_NARROW_CTRL, 8'h20);
    wr(ADDR_NARROW_CTRL, 8'hc2);
    wait_timeout(100, n);
    chk(8'(TIMEOUT_IRQ), 8'h01, "timeout request");
    wr(ADDR_NARROW_CTRL, 8'h42);
    rd(ADDR_NARROW_CTRL, d);
    chk(d & 8'h20, 8'h20, "flag kept by writing zero");
    chk(8'(TIMEOUT_IRQ), 8'h01, "request while flag and mask set");
    wr(ADDR_NARROW_CTRL, 8'h40);
    wait_cyc(2);
    chk(8'(TIMEOUT_IRQ), 8'h00, "request masked");
    wr(ADDR_NARROW_CTRL, 8'h62);
    rd(ADDR_NARROW_CTRL, d);
    chk(d & 8'h20, 8'h00, "flag cleared by writing one");
    wait_cyc(2);
    chk(8'(TIMEOUT_IRQ), 8'h00, "request after clear");
    $display("Test timeout flag done");
  endtask

  task automatic t_clksel();
    int n;
    int div;
    wr(ADDR_NARROW_LOW_HOLD, 8'h08);
    for (int s = 0; s < 4; s++) begin
      div = 1 << s;
      wr(ADDR_NARROW_CTRL, 8'h22);
      wr(ADDR_NARROW_CTRL, 8'hc2 | 8'(s << 3));
      wait_timeout(200, n);
      chk(8'(n >= 7 * div && n <= 9 * div + 4), 8'h01, "time to terminal count");
    end
    wr(ADDR_NARROW_CTRL, 8'h20);
    $display("Test clock select done");
  endtask

  task automatic t_pins();
    logic [7:0] d;
    logic seen0;
    logic seen1;
    irt_pin_model_i.set_port(1'b1, 1'b1);
    wait_cyc(3);
    chk({6'h00, first_pin, third_pin}, 8'h03, "port data on pins");
    irt_pin_model_i.set_port(1'b0, 1'b0);
    wait_cyc(3);
    chk({6'h00, first_pin, third_pin}, 8'h00, "port data on pins");
    wr(ADDR_NARROW_LOW_HOLD, 8'h03);
    wr(ADDR_NARROW_HIGH_HOLD, 8'h03);
    wr(ADDR_NARROW_CTRL, 8'h81);
    irt_pin_model_i.set_port(1'b1, 1'b0);
    seen0 = 1'b0;
    seen1 = 1'b0;
    repeat (60) begin
      wait_cyc(1);
      seen0 = seen0 | (first_pin === 1'b0);
      seen1 = seen1 | (first_pin === 1'b1);
    end
    chk({6'h00, seen0, seen1}, 8'h03, "narrow waveform on first pin");
    rd(ADDR_NARROW_CTRL, d);
    chk(d & 8'ha1, 8'ha1, "modulo run keeps counting");
    wr(ADDR_NARROW_CTRL, 8'h20);
    wr(ADDR_SHARED_CTRL, 8'h4c);
    wait_cyc(3);
    chk({7'h00, third_pin}, 8'h01, "combined output on third pin");
    irt_pin_model_i.set_port(1'b1, 1'b1);
    wr(ADDR_SHARED_CTRL, 8'h68);
    wait_cyc(3);
    chk({7'h00, third_pin}, 8'h00, "combined output on third pin");
    wr(ADDR_SHARED_CTRL, 8'h00);
    $display("Test pin output done");
  endtask

  task automatic t_capture();
    logic [7:0] d;
    wr(ADDR_SHARED_CTRL, 8'h90);
    irt_pin_model_i.set_rx(1'b0);
    wait_cyc(4);
    wr(ADDR_SHARED_CTRL, 8'h93);
    wr(ADDR_WIDE_CTRL, 8'h80);
    wr(ADDR_NARROW_CTRL, 8'ha4);
    wait_cyc(20);
    irt_pin_model_i.set_rx(1'b1);
    wait_cyc(6);
    rd(ADDR_NARROW_CAP_LOW, d);
    chk(8'(d >= 8'd16 && d <= 8'd26), 8'h01, "low period capture");
    rd(ADDR_WIDE_CAP_HIGH, d);
    chk(d, 8'h5d, "wide capture high byte");
    rd(ADDR_WIDE_CAP_LOW, d);
    chk(8'(d >= 8'h40 && d <= 8'h4a), 8'h01, "wide capture low byte");
    rd(ADDR_SHARED_CTRL, d);
    chk(d & 8'h03, 8'h02, "rising edge flag");
    chk(8'(CAPTURE_IRQ), 8'h01, "capture request");
    wr(ADDR_SHARED_CTRL, 8'h92);
    wait_cyc(2);
    chk(8'(CAPTURE_IRQ), 8'h00, "capture request after clear");
    irt_pin_model_i.set_rx(1'b0);
    wait_cyc(6);
    rd(ADDR_SHARED_CTRL, d);
    chk(d & 8'h03, 8'h01, "falling edge flag");
    wait_cyc(10);
    irt_pin_model_i.set_rx(1'b1);
    wait_cyc(6);
    rd(ADDR_NARROW_CAP_LOW, d);
    chk(8'(d >= 8'd14 && d <= 8'd22), 8'h01, "low period capture after high time");
    wr(ADDR_WIDE_CTRL, 8'h20);
    wr(ADDR_NARROW_CTRL, 8'h20);
    $display("Test edge capture done");
  endtask

  initial begin
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    t_reset();
    t_regs();
    t_stop();
    t_timeout();
    t_clksel();
    t_pins();
    t_capture();
    print_verdict();
  end
endmodule // tb_top
